// file: common/boot_guard_pkg.sv
// Shared constants and carriers for the boot select and flash guard block
`default_nettype none
package boot_guard_pkg;
	// ==================== APB map ====================
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  LOCK_OFS   = 8'h04;
	localparam logic [7:0]  STAT_OFS   = 8'h08;
	localparam logic [1:0]  CTRL_RST   = 2'h0;
	localparam int          P2DIS_BIT  = 0;
	localparam int          DFMAP_BIT  = 1;
	// ==================== Flash layout ====================
	localparam logic [19:0] BOOT_CODE_ADDR = 20'h13FF0;
	localparam logic [19:0] VECTOR_ADDR    = 20'hFFFFC;
	localparam logic [19:0] USER_START     = 20'h10000;
	localparam int          NUM_CODE       = 12;
	localparam int          NUM_VEC        = 4;
	localparam int          NUM_ID         = 7;
	localparam int          NUM_RD         = 24;
	// ID bytes, last byte first
	localparam logic [139:0] ID_ADDRS = {20'hFFFFB, 20'hFFFF7, 20'hFFFF3,
		20'hFFFEF, 20'hFFFEB, 20'hFFFE3, 20'hFFFDF};
	// ==================== Patterns, byte 0 in low bits ====================
	localparam logic [63:0] USER_BOOT_SIGNATURE = 64'h746F_6F42_7265_7355;
	localparam logic [55:0] FORCED_ERASE_PATTERN = 56'h45_5341_5265_4C41;
	localparam logic [55:0] SERIAL_OFF_PATTERN   = 56'h74_6365_746F_7250;
	localparam logic [31:0] ERASED_VECTOR        = 32'hFFFF_FFFF;
	localparam logic [7:0]  LEVEL_HIGH_SERIAL    = 8'h00;
	localparam logic [7:0]  LEVEL_LOW_SERIAL     = 8'h01;
	localparam logic [7:0]  MAX_BIT_INDEX        = 8'h07;
	// ==================== Settling of synchronised straps ====================
	localparam logic [1:0]  STRAP_SETTLE = 2'h3;
	// Flash read request carrier
	typedef struct packed {
		logic        rd;
		logic [19:0] addr;
	} flash_req_t;
	// Selected boot outcome carrier
	typedef struct packed {
		logic        done;
		logic        boot_mode;
		logic        user_boot;
		logic        serial_mode;
		logic        serial_off;
		logic        skip_id;
		logic        par_protect;
	} boot_state_t;
endpackage : boot_guard_pkg
`default_nettype wire

// file: hw/boot_guard.sv
// Boot path selection, flash guard and programmer ID check
`timescale 1ns/10ps
`default_nettype none
// Function
// - Boot mode: strap low, other two high
// - Signature mismatch always picks serial mode
// - Zero config bytes give user boot directly
// - Config gives port address and bit index
// - Level select 00h/01h maps sampled bit
// - Only port 0..10 addresses are accepted
// - User boot starts at second area
// - Second area usable while disable bit clear
// - Data flash mapped while map bit set
// - Locked first-area blocks refuse program/erase
// - Read protect bit 0 blocks parallel
// - ID mismatch refuses all further commands
// - Erased reset vector skips the ID check
// - Seven ID bytes from fixed addresses
// - Forced erase pattern is recognised
// - Serial disable pattern is recognised
// - Disable pattern: serial IDs ignored, every command refused
// - Both IDs forced erase: erase user ROM
module boot_guard
	import boot_guard_pkg::*;
#(
	parameter int          NUM_BLK  = 8,
	parameter logic [19:0] OPT_ADDR = 20'hFFFFF,
	parameter int          RCP_BIT  = 0
) (
	// Clock, reset, enable
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Strap pins
	input  wire logic               boot_strap_low_pin,
	input  wire logic               serial_strap_high_pin,
	input  wire logic               processor_mode_pin,
	// Flash and port read channel
	output flash_req_t              fl_req,
	input  wire logic               fl_ack,
	input  wire logic [7:0]         fl_rdata,
	// Boot outcome
	output boot_state_t             boot_st,
	output logic [19:0]             start_addr,
	output logic                    prog2_area_en,
	output logic                    data_flash_map_enable,
	// Serial programmer
	input  wire logic               id_valid,
	input  wire logic [55:0]        id_rx,
	input  wire logic               cmd_valid,
	output logic                    cmd_ok,
	output logic                    cmd_refused,
	output logic                    forced_erase,
	// Parallel programmer
	input  wire logic               par_req,
	output logic                    par_ok,
	output logic                    par_refused,
	// Program or erase on first area
	input  wire logic               op_req,
	input  wire logic [$clog2(NUM_BLK)-1:0] op_blk,
	output logic                    op_ok,
	output logic                    op_refused
);
	// ==================== Types ====================
	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_READ,
		ST_PORT,
		ST_EVAL,
		ST_DONE
	} seq_t;
	typedef enum logic [1:0] {
		ID_WAIT,
		ID_ACCEPT,
		ID_REFUSE
	} id_t;

	// ==================== Strap synchronisers ====================
	logic [2:0] strap_m_r;
	logic [2:0] strap_s_r;
	// Two stages, first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_m_r <= 3'h0;
			strap_s_r <= 3'h0;
		end else if (ce) begin
			strap_m_r <= {boot_strap_low_pin, serial_strap_high_pin, processor_mode_pin};
			strap_s_r <= strap_m_r;
		end
	end

	// ==================== Helper functions ====================
	// Read address for each step of the load list
	function automatic logic [19:0] rd_addr(input logic [4:0] i);
		logic [19:0] a;
		a = OPT_ADDR;
		if (i < 5'(NUM_CODE))
			a = BOOT_CODE_ADDR + 20'(i);
		else if (i < 5'(NUM_CODE + NUM_VEC))
			a = VECTOR_ADDR + 20'(i - 5'(NUM_CODE));
		else if (i < 5'(NUM_RD - 1))
			a = ID_ADDRS[(i - 5'(NUM_CODE + NUM_VEC)) * 20 +: 20];
		return a;
	endfunction : rd_addr

	// Port register addresses P0..P10 only
	function automatic logic port_ok(input logic [15:0] a);
		logic ok;
		ok = 1'b0;
		case (a)
			16'h03E0, 16'h03E1, 16'h03E4, 16'h03E5,
			16'h03E8, 16'h03E9, 16'h03EC, 16'h03ED,
			16'h03F0, 16'h03F1, 16'h03F4: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : port_ok

	// ==================== Boot sequencer state ====================
	seq_t          seq_r;
	seq_t          seq_nxt;
	logic [1:0]    settle_r;
	logic [1:0]    settle_nxt;
	logic [4:0]    idx_r;
	logic [4:0]    idx_nxt;
	logic [191:0]  data_r;
	logic [191:0]  data_nxt;
	logic [7:0]    port_r;
	logic [7:0]    port_nxt;
	logic          bootm_r;
	logic          bootm_nxt;
	flash_req_t    req_r;
	flash_req_t    req_nxt;
	boot_state_t   st_r;
	boot_state_t   st_nxt;
	logic [19:0]   start_r;
	logic [19:0]   start_nxt;

	// Fields of the loaded image
	logic [63:0]   code_sig;
	logic [15:0]   ent_addr;
	logic [7:0]    ent_bit;
	logic [7:0]    ent_lvl;
	logic [31:0]   vec;
	logic [55:0]   id_st;
	logic [7:0]    opt;
	logic          sampled;
	logic          user_sel;
	assign code_sig = data_r[63:0];
	assign ent_addr = data_r[79:64];
	assign ent_bit  = data_r[87:80];
	assign ent_lvl  = data_r[95:88];
	assign vec      = data_r[127:96];
	assign id_st    = data_r[183:128];
	assign opt      = data_r[191:184];
	assign sampled  = port_r[ent_bit[2:0]];

	// Outcome of the boot code field
	always_comb begin
		user_sel = 1'b0;
		if (code_sig != USER_BOOT_SIGNATURE)
			user_sel = 1'b0;
		else if (data_r[95:64] == 32'h0)
			user_sel = 1'b1;
		else if (!port_ok(ent_addr) || ent_bit > MAX_BIT_INDEX)
			user_sel = 1'b0;
		else if (ent_lvl == LEVEL_HIGH_SERIAL)
			user_sel = ~sampled;
		else if (ent_lvl == LEVEL_LOW_SERIAL)
			user_sel = sampled;
		else
			user_sel = 1'b0;
	end

	// Next state of the once-only load and decision
	always_comb begin
		seq_nxt    = seq_r;
		settle_nxt = settle_r;
		idx_nxt    = idx_r;
		data_nxt   = data_r;
		port_nxt   = port_r;
		bootm_nxt  = bootm_r;
		req_nxt    = req_r;
		st_nxt     = st_r;
		start_nxt  = start_r;
		case (seq_r)
			ST_SETTLE: begin
				settle_nxt = settle_r + 2'h1;
				if (settle_r == STRAP_SETTLE) begin
					// Straps caught once, after the synchronisers fill
					bootm_nxt = ~strap_s_r[2] & strap_s_r[1] & strap_s_r[0];
					req_nxt   = '{rd: 1'b1, addr: rd_addr(5'h0)};
					seq_nxt   = ST_READ;
				end
			end
			ST_READ: begin
				if (fl_ack) begin
					data_nxt[idx_r * 8 +: 8] = fl_rdata;
					idx_nxt = idx_r + 5'h1;
					if (idx_r == 5'(NUM_RD - 1)) begin
						req_nxt.rd = 1'b0;
						seq_nxt    = ST_EVAL;
						// Port bit needed only for a valid entry port
						if (bootm_r && code_sig == USER_BOOT_SIGNATURE &&
							data_r[95:64] != 32'h0 && port_ok(ent_addr)) begin
							req_nxt = '{rd: 1'b1, addr: {4'h0, ent_addr}};
							seq_nxt = ST_PORT;
						end
					end else begin
						req_nxt.addr = rd_addr(idx_r + 5'h1);
					end
				end
			end
			ST_PORT: begin
				if (fl_ack) begin
					port_nxt   = fl_rdata;
					req_nxt.rd = 1'b0;
					seq_nxt    = ST_EVAL;
				end
			end
			ST_EVAL: begin
				st_nxt.done        = 1'b1;
				st_nxt.boot_mode   = bootm_r;
				st_nxt.user_boot   = bootm_r & user_sel;
				st_nxt.serial_mode = bootm_r & ~user_sel;
				st_nxt.serial_off  = (id_st == SERIAL_OFF_PATTERN);
				st_nxt.skip_id     = (vec == ERASED_VECTOR);
				st_nxt.par_protect = ~opt[RCP_BIT];
				start_nxt = (bootm_r & user_sel) ? USER_START : vec[19:0];
				seq_nxt   = ST_DONE;
			end
			ST_DONE: begin
				seq_nxt = ST_DONE;
			end
			default: begin
				seq_nxt = ST_SETTLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r    <= ST_SETTLE;
			settle_r <= 2'h0;
			idx_r    <= 5'h0;
			data_r   <= 192'h0;
			port_r   <= 8'h0;
			bootm_r  <= 1'b0;
			req_r    <= '0;
			st_r     <= '0;
			start_r  <= 20'h0;
		end else if (ce) begin
			seq_r    <= seq_nxt;
			settle_r <= settle_nxt;
			idx_r    <= idx_nxt;
			data_r   <= data_nxt;
			port_r   <= port_nxt;
			bootm_r  <= bootm_nxt;
			req_r    <= req_nxt;
			st_r     <= st_nxt;
			start_r  <= start_nxt;
		end
	end

	// ==================== Programmer ID check ====================
	id_t  id_r;
	id_t  id_nxt;
	logic cmd_ok_nxt;
	logic cmd_ref_nxt;
	logic fe_nxt;
	logic ser_live;
	// Serial path exists only in serial mode and without the disable pattern
	assign ser_live = st_r.serial_mode & ~st_r.serial_off;

	always_comb begin
		id_nxt      = id_r;
		cmd_ok_nxt  = 1'b0;
		cmd_ref_nxt = 1'b0;
		fe_nxt      = 1'b0;
		if (ser_live && id_r == ID_WAIT && id_valid) begin
			if (st_r.skip_id)
				id_nxt = ID_ACCEPT;
			else if (id_rx == FORCED_ERASE_PATTERN &&
				(id_st == FORCED_ERASE_PATTERN || !st_r.par_protect)) begin
				fe_nxt = 1'b1;
				id_nxt = ID_ACCEPT;
			end else if (id_rx == id_st && id_st != FORCED_ERASE_PATTERN)
				id_nxt = ID_ACCEPT;
			else
				id_nxt = ID_REFUSE;
		end
		if (cmd_valid) begin
			// Refusal is sticky until the next reset
			cmd_ok_nxt  = ser_live & (id_r == ID_ACCEPT | st_r.skip_id);
			cmd_ref_nxt = ~cmd_ok_nxt;
		end
	end

	logic cmd_ok_r;
	logic cmd_ref_r;
	logic fe_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_r      <= ID_WAIT;
			cmd_ok_r  <= 1'b0;
			cmd_ref_r <= 1'b0;
			fe_r      <= 1'b0;
		end else if (ce) begin
			id_r      <= id_nxt;
			cmd_ok_r  <= cmd_ok_nxt;
			cmd_ref_r <= cmd_ref_nxt;
			fe_r      <= fe_nxt;
		end
	end

	// ==================== APB registers and access checks ====================
	logic [1:0]         ctrl_r;
	logic [1:0]         ctrl_nxt;
	logic [NUM_BLK-1:0] lock_r;
	logic [NUM_BLK-1:0] lock_nxt;
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	logic               rdy_r;
	logic               rdy_nxt;
	logic               err_r;
	logic               err_nxt;
	logic               par_ok_r;
	logic               par_ok_nxt;
	logic               par_ref_r;
	logic               par_ref_nxt;
	logic               op_ok_r;
	logic               op_ok_nxt;
	logic               op_ref_r;
	logic               op_ref_nxt;
	logic               p2_r;
	logic               df_r;
	logic               hit;

	// One wait state; write lands at the pready edge
	always_comb begin
		ctrl_nxt  = ctrl_r;
		lock_nxt  = lock_r;
		rdata_nxt = 32'h0;
		err_nxt   = 1'b0;
		rdy_nxt   = psel & penable & ~rdy_r;
		hit       = (paddr == CTRL_OFS) | (paddr == LOCK_OFS) | (paddr == STAT_OFS);
		if (rdy_nxt) begin
			err_nxt = ~hit;
			case (paddr)
				CTRL_OFS: rdata_nxt = {30'h0, ctrl_r};
				LOCK_OFS: rdata_nxt = 32'(lock_r);
				STAT_OFS: rdata_nxt = {23'h0, id_r, st_r};
				default:  rdata_nxt = 32'h0;
			endcase
		end
		if (rdy_r && psel && penable && pwrite) begin
			if (paddr == CTRL_OFS)
				ctrl_nxt = pwdata[1:0];
			if (paddr == LOCK_OFS)
				lock_nxt = pwdata[NUM_BLK-1:0];
		end
		// Parallel interface stays shut while protected or undecided
		par_ok_nxt  = par_req & st_r.done & ~st_r.par_protect;
		par_ref_nxt = par_req & ~par_ok_nxt;
		op_ok_nxt   = op_req & st_r.done & ~lock_r[op_blk];
		op_ref_nxt  = op_req & ~op_ok_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= CTRL_RST;
			lock_r    <= '0;
			rdata_r   <= 32'h0;
			rdy_r     <= 1'b0;
			err_r     <= 1'b0;
			par_ok_r  <= 1'b0;
			par_ref_r <= 1'b0;
			op_ok_r   <= 1'b0;
			op_ref_r  <= 1'b0;
			p2_r      <= 1'b0;
			df_r      <= 1'b0;
		end else if (ce) begin
			ctrl_r    <= ctrl_nxt;
			lock_r    <= lock_nxt;
			rdata_r   <= rdata_nxt;
			rdy_r     <= rdy_nxt;
			err_r     <= err_nxt;
			par_ok_r  <= par_ok_nxt;
			par_ref_r <= par_ref_nxt;
			op_ok_r   <= op_ok_nxt;
			op_ref_r  <= op_ref_nxt;
			p2_r      <= ~ctrl_nxt[P2DIS_BIT];
			df_r      <= ctrl_nxt[DFMAP_BIT];
		end
	end

	// ==================== Outputs ====================
	assign prdata                = rdata_r;
	assign pready                = rdy_r;
	assign pslverr               = err_r;
	assign fl_req                = req_r;
	assign boot_st               = st_r;
	assign start_addr            = start_r;
	assign prog2_area_en         = p2_r;
	assign data_flash_map_enable = df_r;
	assign cmd_ok                = cmd_ok_r;
	assign cmd_refused           = cmd_ref_r;
	assign forced_erase          = fe_r;
	assign par_ok                = par_ok_r;
	assign par_refused           = par_ref_r;
	assign op_ok                 = op_ok_r;
	assign op_refused            = op_ref_r;
endmodule : boot_guard
`default_nettype wire

// file: sim/boot_guard_checker.sv
// Concurrent checks on the ports of the boot selection and flash guard block
`timescale 1ns/10ps
`default_nettype none
module boot_guard_checker
	import boot_guard_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// Flash read channel and outcome
	input wire flash_req_t  fl_req,
	input wire boot_state_t boot_st,
	input wire logic [19:0] start_addr,
	input wire logic        prog2_area_en,
	input wire logic        data_flash_map_enable,
	// Programmer answers
	input wire logic        cmd_ok,
	input wire logic        par_req,
	input wire logic        par_ok,
	input wire logic        par_refused,
	input wire logic        op_req,
	input wire logic        op_ok,
	input wire logic        op_refused
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==================== Helper state ====================
	logic       ctrl_wr;
	logic [1:0] wd_r, wd_nxt;
	// Last control word, so the check does not depend on pwdata after release
	always_comb begin
		ctrl_wr = psel && penable && pwrite && pready && paddr == CTRL_OFS;
		wd_nxt  = ctrl_wr ? pwdata[1:0] : wd_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wd_r <= 2'h0;
		else
			wd_r <= wd_nxt;
	end
	// ==================== Assertions ====================
	chk_port_addr: assert property (fl_req.rd && fl_req.addr < 20'h10000 |-> fl_req.addr inside {
		20'h003E0, 20'h003E1, 20'h003E4, 20'h003E5, 20'h003E8, 20'h003E9, 20'h003EC, 20'h003ED, 20'h003F0,
		20'h003F1, 20'h003F4}) else $error("entry port read outside port registers");
	chk_user_start: assert property (boot_st.done && boot_st.user_boot |-> start_addr == USER_START)
		else $error("user boot start address wrong");
	chk_mode_hold: assert property (boot_st.done |=> $stable(boot_st) && $stable(start_addr))
		else $error("boot outcome changed before reset");
	chk_area_two: assert property (ctrl_wr |-> ##2 prog2_area_en == !wd_r[P2DIS_BIT])
		else $error("second area enable not following control");
	chk_dflash_map: assert property (ctrl_wr |-> ##2 data_flash_map_enable == wd_r[DFMAP_BIT])
		else $error("data flash map not following control");
	chk_par_guard: assert property (par_req && (!boot_st.done || boot_st.par_protect) |=> par_refused && !par_ok)
		else $error("parallel access let through");
	chk_op_answer: assert property (op_req |=> op_ok != op_refused)
		else $error("block operation answer missing");
	chk_serial_off: assert property (boot_st.serial_off |-> !cmd_ok)
		else $error("command accepted with serial path off");
	// Main scenarios reached
	cov_user: cover property (boot_st.done && boot_st.user_boot);
	cov_serial: cover property (boot_st.done && boot_st.serial_mode);
	cov_lock: cover property (op_refused);
endmodule : boot_guard_checker
bind boot_guard boot_guard_checker chk (.*);
`default_nettype wire

// file: sim/boot_guard_tb.sv
// Self-checking bench for the boot selection and flash guard block
`timescale 1ns/10ps
`default_nettype none
module boot_guard_tb
	import boot_guard_pkg::*;
();
	// ==================== Signals ====================
	typedef struct packed {
		logic [2:0]  strap;
		logic        sig;
		logic [31:0] cfg;
		logic [7:0]  port;
		logic [1:0]  idk;
		logic [6:0]  exp;
	} row_t;
	localparam logic [19:0] OPT_AT   = 20'hFFFDB;
	localparam logic [31:0] VEC      = 32'h0001_2345;
	localparam logic [55:0] PLAIN_ID = 56'h07_0605_0403_0201;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, fl_ack, id_valid, cmd_valid;
	logic        cmd_ok, cmd_refused, forced_erase, par_req, par_ok, par_refused, op_req, op_ok, op_refused;
	logic        boot_strap_low_pin, serial_strap_high_pin, processor_mode_pin, prog2_area_en;
	logic        data_flash_map_enable, e;
	logic [7:0]  paddr, fl_rdata;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] start_addr;
	logic [55:0] id_rx;
	logic [2:0]  op_blk;
	logic [1:0]  lag;
	flash_req_t  fl_req;
	boot_state_t boot_st;
	int          failures, compares;
	row_t        rows [12];
	boot_guard #(.NUM_BLK(8), .OPT_ADDR(OPT_AT), .RCP_BIT(0)) dut (.*);
	flash_model fm (.*);
	// ==================== Clock and watchdog ====================
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	// A full run needs a few thousand cycles; twenty thousand means a hang
	initial begin
		#1000000;
		failures++;
		finish_test();
	end
	// ==================== Tasks ====================
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'h1) begin
			failures++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// Load flash image, apply straps, reset and wait for the decision
	task automatic boot(input row_t r);
		logic [95:0] cd;
		logic [55:0] id;
		logic [31:0] vec;
		int          n;
		cd  = {r.cfg, r.sig ? USER_BOOT_SIGNATURE : 64'h0};
		id  = r.idk == 2'h1 ? FORCED_ERASE_PATTERN : r.idk == 2'h2 ? SERIAL_OFF_PATTERN : PLAIN_ID;
		vec = r.idk == 2'h3 ? ERASED_VECTOR : VEC;
		for (int i = 0; i < NUM_CODE; i++)
			fm.mem[20'(BOOT_CODE_ADDR + i)] = cd[8*i+:8];
		for (int i = 0; i < NUM_VEC; i++)
			fm.mem[20'(VECTOR_ADDR + i)] = vec[8*i+:8];
		for (int i = 0; i < NUM_ID; i++)
			fm.mem[ID_ADDRS[20*i+:20]] = id[8*i+:8];
		fm.mem[{4'h0, r.cfg[15:0]}] = r.port;
		// Protection only changes by rewriting flash, never over the parallel path
		fm.mem[OPT_AT] = {7'h0, !r.exp[0]};
		{boot_strap_low_pin, serial_strap_high_pin, processor_mode_pin} <= r.strap;
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		n = 0;
		while (boot_st.done !== 1'h1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(n < 400, "boot never finished");
	endtask : boot
	// One APB transfer; waits on pready, bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge, so a following call never drives psel twice in one step
		@(posedge pclk);
		chk(n < 20, "no pready");
	endtask : apb
	task automatic send_id(input logic [55:0] v);
		id_rx <= v;
		id_valid <= 1'h1;
		@(posedge pclk);
		id_valid <= 1'h0;
		@(posedge pclk);
	endtask : send_id
	task automatic cmd(input logic ok, input logic strict);
		cmd_valid <= 1'h1;
		@(posedge pclk);
		cmd_valid <= 1'h0;
		@(posedge pclk);
		chk(cmd_ok === ok && (!strict || cmd_refused === !ok), "command answer");
	endtask : cmd
	// ==================== Tests ====================
	initial begin
		failures = 0;
		compares = 0;
		presetn = 1'h0;
		ce = 1'h1;
		{psel, penable, pwrite, paddr, pwdata, id_valid, id_rx, cmd_valid, par_req, op_req, op_blk, lag} = '0;
		{boot_strap_low_pin, serial_strap_high_pin, processor_mode_pin} = 3'h7;
		// Straps, signature, config, port byte, stored ID kind, expected outcome
		rows = '{'{3'h7, 1'h1, 32'h0, 8'h00, 2'h0, 7'h40}, '{3'h2, 1'h1, 32'h0, 8'h00, 2'h0, 7'h40},
			'{3'h3, 1'h0, 32'h0, 8'h00, 2'h0, 7'h68}, '{3'h3, 1'h1, 32'h0, 8'h00, 2'h0, 7'h71},
			'{3'h3, 1'h1, 32'h0007_03E9, 8'h80, 2'h0, 7'h68}, '{3'h3, 1'h1, 32'h0007_03E9, 8'h7F, 2'h0, 7'h70},
			'{3'h3, 1'h1, 32'h0100_03F4, 8'h01, 2'h0, 7'h70}, '{3'h3, 1'h1, 32'h0103_03E0, 8'hF7, 2'h0, 7'h68},
			'{3'h3, 1'h1, 32'h0000_03E2, 8'h00, 2'h0, 7'h68}, '{3'h3, 1'h0, 32'h0, 8'h00, 2'h2, 7'h6C},
			'{3'h3, 1'h0, 32'h0, 8'h00, 2'h3, 7'h6B}, '{3'h3, 1'h0, 32'h0, 8'h00, 2'h1, 7'h68}};
		repeat (2) @(posedge pclk);
		// Table of ordinary boot cases, with slow and prompt flash
		for (int i = 0; i < 12; i++) begin
			lag <= 2'(i % 3);
			boot(rows[i]);
			chk((boot_st & (rows[i].strap == 3'h3 ? 7'h7F : 7'h78)) === rows[i].exp, "outcome");
			// An erased vector row starts from the erased reset vector, not the programmed one
			chk(start_addr === (rows[i].exp[4] ? USER_START :
				(rows[i].idk == 2'h3 ? ERASED_VECTOR[19:0] : VEC[19:0])), "start address");
			par_req <= 1'h1;
			@(posedge pclk);
			par_req <= 1'h0;
			@(posedge pclk);
			chk(par_refused === rows[i].exp[0] && par_ok === !rows[i].exp[0], "parallel guard");
			$display("row %0d done", i);
		end
		// Registers: reset value, write effect, read-only status, unmapped place
		boot(rows[2]);
		apb(1'h0, CTRL_OFS, 32'h0);
		chk(q === 32'h0 && prog2_area_en === 1'h1 && data_flash_map_enable === 1'h0, "control reset");
		apb(1'h1, CTRL_OFS, 32'h3);
		apb(1'h1, STAT_OFS, 32'hFFFF_FFFF);
		apb(1'h0, STAT_OFS, 32'h0);
		chk(q === 32'h68 && prog2_area_en === 1'h0 && data_flash_map_enable === 1'h1, "status and control");
		apb(1'h0, 8'h0C, 32'h0);
		chk(e === 1'h1 && q === 32'h0, "unmapped read");
		apb(1'h1, LOCK_OFS, 32'h4);
		for (int b = 2; b < 4; b++) begin
			op_blk <= 3'(b);
			op_req <= 1'h1;
			@(posedge pclk);
			op_req <= 1'h0;
			@(posedge pclk);
			chk(op_refused === (b == 2) && op_ok === (b != 2), "block lock");
		end
		$display("register test done");
		// Wrong ID stays refused even after the right one follows
		send_id(56'h0);
		cmd(1'h0, 1'h1);
		send_id(PLAIN_ID);
		cmd(1'h0, 1'h1);
		boot(rows[2]);
		send_id(PLAIN_ID);
		cmd(1'h1, 1'h1);
		// Forced erase when both sides carry the reserved word, or when the received one does and parallel protect is off
		boot(rows[11]);
		send_id(FORCED_ERASE_PATTERN);
		chk(forced_erase === 1'h1, "forced erase");
		boot(rows[11]);
		send_id(PLAIN_ID);
		chk(forced_erase === 1'h0, "no forced erase");
		cmd(1'h0, 1'h1);
		// Serial path off, then erased vector skipping the compare
		boot(rows[9]);
		send_id(SERIAL_OFF_PATTERN);
		cmd(1'h0, 1'h0);
		boot(rows[10]);
		cmd(1'h1, 1'h1);
		$display("serial test done");
		finish_test();
	end
endmodule : boot_guard_tb
`default_nettype wire

// file: sim/flash_model.sv
// Flash array and port register model answering the boot read channel
`timescale 1ns/10ps
`default_nettype none
module flash_model
	import boot_guard_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Read channel
	input  wire flash_req_t fl_req,
	output logic            fl_ack,
	output logic [7:0]      fl_rdata,
	// Wait cycles before each answer
	input  wire logic [1:0] lag
);
	logic [7:0] mem [logic [19:0]];
	logic [1:0] cnt;
	// One answer per request; data toggles so stale bytes never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_ack   <= 1'h0;
			cnt      <= 2'h0;
			fl_rdata <= 8'h5A;
		end else if (fl_req.rd && !fl_ack && cnt == lag) begin
			fl_ack   <= 1'h1;
			cnt      <= 2'h0;
			fl_rdata <= mem.exists(fl_req.addr) ? mem[fl_req.addr] : 8'hFF; // Unwritten cells read erased
		end else begin
			fl_ack   <= 1'h0;
			cnt      <= (fl_req.rd && !fl_ack) ? cnt + 2'h1 : 2'h0;
			fl_rdata <= ~fl_rdata;
		end
	end
endmodule : flash_model
`default_nettype wire
